// *** src/pit_timer.sv ***
// Functional notes
// (R1) 16-bit down-counter steps every n cycles
// (R2) interval n comes from 8-bit scale register
// (R3) interrupt request when counter reaches zero
// (R4) zero reloads counter from 16-bit period
// (R5) timer interrupt offered as on-chip source
// (R6) prescaler restarts from scale on each tick
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pit_timer #(
   parameter int COUNT_W = pit_pkg::COUNT_W,
   parameter int SCALE_W = pit_pkg::SCALE_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // wishbone classic slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [pit_pkg::ADR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_wdata,
   output logic [31:0] wb_rdata,
   output logic wb_ack,
   // interrupt to the processor interrupt logic
   output logic timer_irq
);

   // ==========================================
   // decode helpers
   function automatic logic hit(input logic [pit_pkg::ADR_W-1:0] adr, input logic [7:0] off);
      hit = (adr[7:2] == off[7:2]);
   endfunction : hit

   function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
      lane16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction : lane16

   // ==========================================
   // state
   logic [COUNT_W-1:0] count_reg, count_next;
   logic [SCALE_W-1:0] scale_reg, scale_next;
   logic [COUNT_W-1:0] period_reg, period_next;
   logic [SCALE_W-1:0] presc_reg, presc_next;
   logic run_reg, run_next;
   logic [pit_pkg::EVT_W-1:0] status_reg, status_next;
   logic [pit_pkg::EVT_W-1:0] mask_reg, mask_next;
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;

   logic req;
   logic wr;
   logic tick;
   logic zero_evt;
   logic [pit_pkg::EVT_W-1:0] evt;

   assign req = wb_cyc & wb_stb & ~ack_reg;
   assign wr = req & wb_we;

   // ==========================================
   // timer and register next state
   always_comb begin
      count_next = count_reg;
      scale_next = scale_reg;
      period_next = period_reg;
      presc_next = presc_reg;
      run_next = run_reg;
      mask_next = mask_reg;
      tick = 1'b0;
      zero_evt = 1'b0;
      // prescaler: tick when it hits zero, then restart from scale
      if (run_reg) begin
         if (presc_reg == '0) begin
            tick = 1'b1;
            presc_next = scale_reg; // [R6] [R2]
         end else begin
            presc_next = presc_reg - 1'b1;
         end
      end
      if (tick) begin
         if (count_reg == '0) begin
            zero_evt = 1'b1; // [R3]
            count_next = period_reg; // [R4]
         end else begin
            count_next = count_reg - 1'b1; // [R1]
         end
      end
      // software writes win over the counter in the same cycle
      if (wr && hit(wb_adr, pit_pkg::OFF_DOWN_COUNT)) begin
         count_next = lane16(count_reg, wb_wdata, wb_sel);
      end
      if (wr && hit(wb_adr, pit_pkg::OFF_PRESCALE) && wb_sel[0]) begin
         scale_next = wb_wdata[SCALE_W-1:0]; // [R2]
         presc_next = wb_wdata[SCALE_W-1:0]; // [R6]
      end
      if (wr && hit(wb_adr, pit_pkg::OFF_PERIOD)) begin
         period_next = lane16(period_reg, wb_wdata, wb_sel);
      end
      if (wr && hit(wb_adr, pit_pkg::OFF_CONTROL) && wb_sel[0]) begin
         run_next = wb_wdata[pit_pkg::CTRL_RUN_BIT];
         presc_next = scale_reg;
      end
      if (wr && hit(wb_adr, pit_pkg::OFF_MASK) && wb_sel[0]) begin
         mask_next = wb_wdata[pit_pkg::EVT_W-1:0];
      end
   end

   // ==========================================
   // status, interrupt and bus answer
   always_comb begin
      evt = '0;
      evt[pit_pkg::EVT_ZERO_BIT] = zero_evt;
      status_next = status_reg;
      // write one clears; a same-cycle event still sets
      if (wr && hit(wb_adr, pit_pkg::OFF_STATUS) && wb_sel[0]) begin
         status_next = status_reg & ~wb_wdata[pit_pkg::EVT_W-1:0];
      end
      status_next = status_next | evt; // [R3]
      irq_next = |(status_next & mask_next); // [R5]
      ack_next = req;
      rdata_next = 32'h0000_0000;
      if (req && !wb_we) begin
         if (hit(wb_adr, pit_pkg::OFF_DOWN_COUNT)) begin
            rdata_next[COUNT_W-1:0] = count_reg;
         end else if (hit(wb_adr, pit_pkg::OFF_PRESCALE)) begin
            rdata_next[SCALE_W-1:0] = scale_reg;
         end else if (hit(wb_adr, pit_pkg::OFF_PERIOD)) begin
            rdata_next[COUNT_W-1:0] = period_reg;
         end else if (hit(wb_adr, pit_pkg::OFF_CONTROL)) begin
            rdata_next[pit_pkg::CTRL_RUN_BIT] = run_reg;
         end else if (hit(wb_adr, pit_pkg::OFF_STATUS)) begin
            rdata_next[pit_pkg::EVT_W-1:0] = status_reg;
         end else if (hit(wb_adr, pit_pkg::OFF_MASK)) begin
            rdata_next[pit_pkg::EVT_W-1:0] = mask_reg;
         end
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         count_reg <= pit_pkg::RST_DOWN_COUNT;
         scale_reg <= pit_pkg::RST_PRESCALE;
         period_reg <= pit_pkg::RST_PERIOD;
         presc_reg <= pit_pkg::RST_PRESCALE;
         run_reg <= pit_pkg::RST_RUN;
         status_reg <= pit_pkg::RST_STATUS;
         mask_reg <= pit_pkg::RST_MASK;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         irq_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         scale_reg <= scale_next;
         period_reg <= period_next;
         presc_reg <= presc_next;
         run_reg <= run_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign wb_ack = ack_reg;
   assign wb_rdata = rdata_reg;
   assign timer_irq = irq_reg;

endmodule : pit_timer
`default_nettype wire

// *** include/pit_pkg.sv ***
// ==========================================
// prescaled interval timer constants
package pit_pkg;
   // ==========================================
   // widths
   localparam int COUNT_W = 16;
   localparam int SCALE_W = 8;
   localparam int ADR_W = 8;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] OFF_DOWN_COUNT = 8'h00;
   localparam logic [7:0] OFF_PRESCALE = 8'h04;
   localparam logic [7:0] OFF_PERIOD = 8'h08;
   localparam logic [7:0] OFF_CONTROL = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   // ==========================================
   // field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int EVT_ZERO_BIT = 0;
   localparam int EVT_W = 1;
   // ==========================================
   // reset values
   localparam logic [15:0] RST_DOWN_COUNT = 16'h0000;
   localparam logic [7:0] RST_PRESCALE = 8'h00;
   localparam logic [15:0] RST_PERIOD = 16'h0000;
   localparam logic RST_RUN = 1'b0;
   localparam logic [0:0] RST_STATUS = 1'h0;
   localparam logic [0:0] RST_MASK = 1'h0;
endpackage : pit_pkg

// *** bench/pit_timer_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// bus and interrupt checks
module pit_timer_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // watched ports
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [31:0] wb_rdata,
   input wire logic wb_ack,
   input wire logic timer_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence req_s;
      wb_cyc && wb_stb && !wb_ack;
   endsequence
   ack_latency_a: assert property (req_s |=> wb_ack) else $error("late ack");
   ack_pulse_a: assert property (wb_ack |=> !wb_ack) else $error("long ack");
   ack_cause_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb)) else $error("stray ack");
   rdata_idle_a: assert property (!wb_ack |-> wb_rdata == 32'h0) else $error("rdata idle");
   wr_rdata_a: assert property (wb_ack && $past(wb_we) |-> wb_rdata == 32'h0) else $error("wr rdata");
   // only software can drop a pending request
   irq_sticky_a: assert property ($fell(timer_irq) |-> $past(wb_we, 1) || $past(wb_we, 2))
      else $error("irq dropped");
endmodule : pit_timer_asserts
bind pit_timer pit_timer_asserts i_chk (.clk(clk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
   .wb_we(wb_we), .wb_rdata(wb_rdata), .wb_ack(wb_ack), .timer_irq(timer_irq));
`default_nettype wire

// *** bench/pit_irq_sink.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========
// interrupt logic model: counts requests and their spacing
module pit_irq_sink (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // request level
   input wire logic irq,
   // observations
   output logic [15:0] gap,
   output logic [7:0] rises
);
   logic prev_reg;
   logic [15:0] cnt_reg;
   always_ff @(posedge clk) begin
      prev_reg <= nrst & irq;
      cnt_reg <= (nrst && !(irq && !prev_reg)) ? cnt_reg + 16'h1 : 16'h1;
      if (!nrst) rises <= 8'h0;
      else if (irq && !prev_reg) rises <= rises + 8'h1;
      if (irq && !prev_reg) gap <= cnt_reg;
   end
endmodule : pit_irq_sink
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ==========
   // signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wd = 32'h0, rd;
   logic ack, irq;
   logic [15:0] gap;
   logic [7:0] rises;
   int fail_count = 0, tests_run = 0, cycles = 0;
   logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
   logic [31:0] rw [5] = '{32'h0000ffff, 32'h000001ff, 32'hffff1234, 32'h3, 32'h5};
   logic [31:0] re [5] = '{32'h0000ffff, 32'h000000ff, 32'h00001234, 32'h1, 32'h0};
   pit_timer i_dut (.clk(clk), .nrst(nrst), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
      .wb_sel(sel), .wb_wdata(wd), .wb_rdata(rd), .wb_ack(ack), .timer_irq(irq));
   pit_irq_sink i_sink (.clk(clk), .nrst(nrst), .irq(irq), .gap(gap), .rises(rises));
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         conclude();
      end
   end
   // ==========
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : xfer
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // ==========
   // sequence
   initial begin
      logic [31:0] q;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         xfer(1'b1, ra[i], rw[i], q);
         xfer(1'b0, ra[i], 32'h0, q);
         chk(q, re[i]);
      end
      // scale 2, period 3: one request every 12 cycles
      xfer(1'b1, pit_pkg::OFF_PRESCALE, 32'h2, q);
      xfer(1'b1, pit_pkg::OFF_PERIOD, 32'h3, q);
      xfer(1'b1, pit_pkg::OFF_DOWN_COUNT, 32'h1, q);
      xfer(1'b1, pit_pkg::OFF_CONTROL, 32'h1, q);
      repeat (3) begin
         while (irq !== 1'b1) @(posedge clk);
         xfer(1'b1, pit_pkg::OFF_STATUS, 32'h1, q);
         @(posedge clk);
      end
      chk({16'h0, gap}, 32'hc);
      chk({24'h0, rises}, 32'h3);
      while (irq !== 1'b1) @(posedge clk);
      xfer(1'b1, pit_pkg::OFF_MASK, 32'h0, q);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b0, pit_pkg::OFF_STATUS, 32'h0, q);
      chk(q, 32'h1);
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      xfer(1'b0, pit_pkg::OFF_DOWN_COUNT, 32'h0, q);
      chk(q, 32'h0);
      // upper lane only: the low byte must keep its reset value
      sel <= 4'h2;
      xfer(1'b1, pit_pkg::OFF_PERIOD, 32'h0000abcd, q);
      sel <= 4'hf;
      xfer(1'b0, pit_pkg::OFF_PERIOD, 32'h0, q);
      chk(q, 32'h0000ab00);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
